// ===== core/lcd_cmd_dev.sv
`timescale 1ns/1ps
// Purpose: Command decoder of the LCD controller
// Assumes: Link inputs arrive from pins, synchronised here
// Notes:   Byte taken on the rising edge of wr_n; all outputs registered
//          Second bytes of paired commands are tracked by a small pending state
//          Power save is a mode, not a code: display off plus entire display on
//          Column stepping and the analog supplies live outside this block
//          Undefined codes are dropped, never trapped or reported
module lcd_cmd_dev
   import lcd_cmd_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   lcd_cmd_if.dev          link,
   output logic            display_on_o,
   output logic            entire_on_o,
   output logic            bias_sel_o,
   output logic            rmw_mode_o,
   output logic            com_reverse_o,
   output logic [2:0]      power_mode_o,
   output logic [2:0]      regulator_resistor_ratio_o,
   output logic [5:0]      contrast_volume_o,
   output logic            indicator_on_o,
   output logic [1:0]      indicator_flash_mode_o,
   output logic            test_mode_o,
   output logic [1:0]      power_state_o,
   output logic            osc_run_o,
   output logic            outputs_grounded_o,
   output logic            ram_we_o,
   output logic [7:0]      ram_data_o
);
   // Whole state in one packed word: sync chain, settings, pairing, power
   typedef struct packed {
      logic [2:0]  wr_sync;
      logic [2:0]  rs_sync;
      logic [23:0] d_sync;
      logic        wr_lvl;
      logic        disp_on;
      logic        entire;
      logic        bias;
      logic        rmw;
      logic        com_rev;
      logic [2:0]  pwr;
      logic [2:0]  ratio;
      logic [5:0]  vol;
      logic        ind_on;
      logic [1:0]  flash;
      logic        test;
      lcd_expect_t pend;     // What the next command byte means
      lcd_pmode_t  pm;       // Normal, standby or sleep
      logic        osc;      // Oscillator running
      logic        gnd;      // Drivers parked at ground
      logic        ram_we;
      logic [7:0]  ram_data;
   } lcd_dev_state_t;

   lcd_dev_state_t s;
   lcd_dev_state_t next_s;
   // Strobe, select and byte as seen after synchronising
   logic           wr_now;
   logic           rs_now;
   logic [7:0]     byte_now;
   logic           take;

   // Stage two and three agree before a change counts.
   // The first stage may be metastable, so only the shift reads it.
   // Select and data ride the same depth, so they line up with the strobe.
   assign wr_now   = (s.wr_sync[1] == s.wr_sync[2]) ? s.wr_sync[1] : s.wr_lvl;
   assign rs_now   = s.rs_sync[2];
   assign byte_now = s.d_sync[23:16];
   assign take     = wr_now & ~s.wr_lvl; // Rising strobe ends the write

   // Default settings, shared by reset pin and reset command.
   // Display on/off and entire display are left alone: they form the
   // power save pair, and a reset in standby must be able to settle in sleep.
   // The pin reset starts from all zeros, so the display comes up off anyway.
   function automatic lcd_dev_state_t defaults(input lcd_dev_state_t c);
      lcd_dev_state_t r;
      r         = c;
      r.bias    = 1'b0;
      r.rmw     = 1'b0;
      r.com_rev = 1'b0;
      r.pwr     = LCD_PWR_RST;
      r.ratio   = LCD_RATIO_RST;
      r.vol     = LCD_VOL_RST;
      r.ind_on  = 1'b0;
      r.flash   = LCD_FLASH_RST;
      r.test    = 1'b0;
      r.pend    = LCD_EXP_CMD;
      return r;
   endfunction

   // Decode one byte per write strobe
   always_comb begin
      next_s         = s;
      next_s.wr_sync = {s.wr_sync[1:0], link.wr_n};
      next_s.rs_sync = {s.rs_sync[1:0], link.register_select};
      next_s.d_sync  = {s.d_sync[15:0], link.data};
      next_s.wr_lvl  = wr_now;
      next_s.ram_we  = 1'b0;
      // Data bytes skip the decoder and leave a pending pair open
      if (take && rs_now) begin
         next_s.ram_we   = 1'b1; // Data goes to display RAM [RULE_20]
         next_s.ram_data = byte_now;
      end else if (take) begin // Command only with select low [RULE_20]
         // A pending second byte is never decoded as a command, so a
         // contrast byte of 0xff or a flash byte in the test range is safe
         case (s.pend)
            LCD_EXP_VOLUME: begin
               next_s.vol  = byte_now[LCD_VOL_W-1:0]; // Upper bits dropped [RULE_08]
               next_s.pend = LCD_EXP_CMD;
            end
            LCD_EXP_FLASH: begin
               next_s.flash = byte_now[LCD_FLASH_W-1:0]; // [RULE_10]
               next_s.pend  = LCD_EXP_CMD;
            end
            default: begin
               if (lcd_match(byte_now, LCD_CMD_DISP_OFF, LCD_MASK_LSB1)) begin
                  next_s.disp_on = byte_now[0]; // [RULE_16]
               end else if (lcd_match(byte_now, LCD_CMD_ENTIRE_OFF, LCD_MASK_LSB1)) begin
                  next_s.entire = byte_now[0]; // [RULE_01]
               end else if (lcd_match(byte_now, LCD_CMD_BIAS0, LCD_MASK_LSB1)) begin
                  next_s.bias = byte_now[0]; // [RULE_02]
               end else if (byte_now == LCD_CMD_RMW) begin
                  // Column stepping lives outside; only the mode flag is kept
                  next_s.rmw = 1'b1; // [RULE_03]
               end else if (byte_now == LCD_CMD_END) begin
                  next_s.rmw = 1'b0; // [RULE_04]
               end else if (byte_now == LCD_CMD_RESET) begin
                  next_s = defaults(next_s); // Also leaves test mode [RULE_19]
                  if (s.pm == LCD_PM_STANDBY) begin
                     // Display pair kept, so the release below cannot undo this
                     next_s.pm = LCD_PM_SLEEP; // [RULE_17]
                  end
               end else if (byte_now == LCD_CMD_NOP) begin
                  next_s.pend = LCD_EXP_CMD; // No change of state [RULE_19]
               end else if (lcd_match(byte_now, LCD_CMD_COM_DIR, LCD_MASK_COM)) begin
                  // Bits 2 to 0 are don't care
                  next_s.com_rev = byte_now[LCD_COM_DIR_BIT]; // [RULE_05]
               end else if (lcd_match(byte_now, LCD_CMD_POWER, LCD_MASK_LSB3)) begin
                  next_s.pwr = byte_now[LCD_FIELD3_W-1:0]; // [RULE_06]
               end else if (lcd_match(byte_now, LCD_CMD_RATIO, LCD_MASK_LSB3)) begin
                  next_s.ratio = byte_now[LCD_FIELD3_W-1:0]; // [RULE_07]
               end else if (byte_now == LCD_CMD_VOLUME) begin
                  next_s.pend = LCD_EXP_VOLUME; // [RULE_08]
               end else if (lcd_match(byte_now, LCD_CMD_IND_OFF, LCD_MASK_LSB1)) begin
                  next_s.ind_on = byte_now[0]; // [RULE_09]
                  next_s.pend   = LCD_EXP_FLASH; // [RULE_10]
               end else if (byte_now == LCD_CMD_TEST_EXIT) begin
                  next_s.test = 1'b0; // [RULE_13]
               end else if (lcd_match(byte_now, LCD_CMD_TEST_EXIT, LCD_MASK_TEST)) begin
                  next_s.test = 1'b1; // Host should never send these [RULE_12]
               end
               // Any other code is dropped without effect; software must not
               // lean on that, it is no promise of future behaviour
            end
         endcase
      end

      // Power save: display off with entire display on [RULE_11].
      // Checked every cycle, so the two halves may come in either order;
      // the indicator picks standby or sleep on entry only.
      if (s.pm == LCD_PM_NORMAL && !next_s.disp_on && next_s.entire) begin
         next_s.pm = next_s.ind_on ? LCD_PM_STANDBY : LCD_PM_SLEEP;
      end else if (s.pm != LCD_PM_NORMAL && (next_s.disp_on || !next_s.entire)) begin
         next_s.pm = LCD_PM_NORMAL; // Release by power save off
      end
      // Status flops follow the next power state, so the pins carry no decode
      // glitch; sleep stops the oscillator, both low modes ground the drivers
      next_s.osc = (next_s.pm != LCD_PM_SLEEP); // [RULE_18]
      next_s.gnd = (next_s.pm != LCD_PM_NORMAL); // [RULE_18]
   end

   // Single state register; strobe sync stages and level reset high.
   // Idle-high sync stages keep reset from looking like a strobe edge,
   // which would otherwise decode a stale byte on the link.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s         <= defaults('0);
         s.wr_sync <= 3'h7;
         s.wr_lvl  <= 1'b1;
         s.pm      <= LCD_PM_NORMAL;
         s.osc     <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs driven straight from state flops.
   // No output is decoded here, so downstream logic sees clean levels
   // even while the power state moves.
   assign display_on_o               = s.disp_on;
   assign entire_on_o                = s.entire;
   assign bias_sel_o                 = s.bias;
   assign rmw_mode_o                 = s.rmw;
   assign com_reverse_o              = s.com_rev;
   assign power_mode_o               = s.pwr;
   assign regulator_resistor_ratio_o = s.ratio;
   assign contrast_volume_o          = s.vol;
   assign indicator_on_o             = s.ind_on;
   assign indicator_flash_mode_o     = s.flash;
   assign test_mode_o                = s.test;
   assign power_state_o              = s.pm;
   // Sleep stops oscillator, grounds drivers; settings kept [RULE_18]
   assign osc_run_o                  = s.osc;
   assign outputs_grounded_o         = s.gnd;
   assign ram_we_o                   = s.ram_we; // RAM stays writable in sleep
   assign ram_data_o                 = s.ram_data;
endmodule

// ===== core/lcd_cmd_host.sv
`timescale 1ns/1ps
// Purpose: Host end: Wishbone slave that issues bytes on the LCD link
// Assumes: Software keeps to defined codes and power sequence waits
// Notes:   One byte per CTRL write; busy until the strobe completes
module lcd_cmd_host
   import lcd_cmd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   lcd_cmd_if.host          link
);
   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      logic        busy;
      logic [3:0]  cnt;
      logic        phase;  // 0 strobe low, 1 recovery high
      logic        rs;
      logic [7:0]  data;
      logic        wr_n;
   } lcd_host_state_t;

   lcd_host_state_t s;
   lcd_host_state_t next_s;
   logic            req;

   assign req = wb_cyc_i & wb_stb_i & ~s.ack;

   // Bus decode and strobe sequencing; the byte stays out while busy
   always_comb begin
      next_s      = s;
      next_s.ack  = req;
      next_s.rdat = '0;
      if (req && !wb_we_i && wb_adr_i == LCD_REG_STAT) begin
         next_s.rdat = {31'h0, s.busy};
      end
      // Software is trusted to send only defined codes [RULE_14] [RULE_12]
      // Power sequence waits are timed by software between writes [RULE_15]
      if (req && wb_we_i && wb_adr_i == LCD_REG_CTRL && !s.busy && wb_sel_i[0]) begin
         next_s.busy  = 1'b1;
         next_s.data  = wb_dat_i[7:0];
         next_s.rs    = wb_sel_i[1] & wb_dat_i[LCD_CTRL_RS_BIT];
         next_s.wr_n  = 1'b0;
         next_s.phase = 1'b0;
         next_s.cnt   = LCD_STROBE_CNT;
      end else if (s.busy) begin
         if (s.cnt != 4'h0) begin
            next_s.cnt = s.cnt - 4'h1;
         end else if (!s.phase) begin
            next_s.wr_n  = 1'b1; // Rising edge latches the byte
            next_s.phase = 1'b1;
            next_s.cnt   = LCD_STROBE_CNT;
         end else begin
            next_s.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s      <= '0;
         s.wr_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign wb_ack_o             = s.ack;
   assign wb_dat_o             = s.rdat;
   assign link.wr_n            = s.wr_n;
   assign link.data            = s.data;
   assign link.register_select = s.rs;
endmodule

// ===== core/lcd_cmd_if.sv
`timescale 1ns/1ps
// Purpose: Parallel write link between host controller and LCD decoder
// Assumes: Both ends on clk_i; device samples wr_n through three flops
// Notes:   Write-only 8080 style: register select, data, write strobe low
interface lcd_cmd_if;
   logic       register_select;
   logic [7:0] data;
   logic       wr_n;

   modport host (output register_select, output data, output wr_n);
   modport dev  (input register_select, input data, input wr_n);
endinterface

// ===== core/lcd_cmd_pkg.sv
// Purpose: Shared constants and types for the LCD command decoder ends
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   Command codes, field positions, reset values and timing counts
//
// Functional notes
// RULE_01 - A4 normal display, A5 all dots on
// RULE_02 - A2/A3 low bit selects drive bias
// RULE_03 - E0 enters read-modify-write, reads keep column
// RULE_04 - EE leaves read-modify-write mode
// RULE_05 - C0/C8 scan direction from bit three
// RULE_06 - 28..2F load power circuit mode
// RULE_07 - 20..27 load regulator resistor ratio
// RULE_08 - 81 then six-bit contrast value byte
// RULE_09 - AC/AD turn static indicator off/on
// RULE_10 - Indicator command followed by flash mode byte
// RULE_11 - Display off plus entire on means power save
// RULE_12 - Host never sends F1 to FF
// RULE_13 - F0 leaves test mode
// RULE_14 - Host sends only defined command codes
// RULE_15 - Host waits about 5 ms in power sequences
// RULE_16 - AE/AF turn panel display off/on
// RULE_17 - Reset command in standby enters sleep
// RULE_18 - Sleep stops circuits, grounds outputs, keeps settings
// RULE_19 - E2 restores defaults, E3 does nothing
// RULE_20 - Commands only with register select low
package lcd_cmd_pkg;
   // Command codes
   localparam logic [7:0] LCD_CMD_DISP_OFF   = 8'hae;
   localparam logic [7:0] LCD_CMD_ENTIRE_OFF = 8'ha4;
   localparam logic [7:0] LCD_CMD_BIAS0      = 8'ha2;
   localparam logic [7:0] LCD_CMD_RMW        = 8'he0;
   localparam logic [7:0] LCD_CMD_END        = 8'hee;
   localparam logic [7:0] LCD_CMD_RESET      = 8'he2;
   localparam logic [7:0] LCD_CMD_NOP        = 8'he3;
   localparam logic [7:0] LCD_CMD_VOLUME     = 8'h81;
   localparam logic [7:0] LCD_CMD_IND_OFF    = 8'hac;
   localparam logic [7:0] LCD_CMD_TEST_EXIT  = 8'hf0;
   localparam logic [7:0] LCD_CMD_COM_DIR    = 8'hc0;
   localparam logic [7:0] LCD_CMD_POWER      = 8'h28;
   localparam logic [7:0] LCD_CMD_RATIO      = 8'h20;
   // Masks that pick the fixed part of each code
   localparam logic [7:0] LCD_MASK_LSB1      = 8'hfe;
   localparam logic [7:0] LCD_MASK_LSB3      = 8'hf8;
   localparam logic [7:0] LCD_MASK_COM       = 8'hf0;
   localparam logic [7:0] LCD_MASK_TEST      = 8'hf0;
   localparam int         LCD_COM_DIR_BIT    = 3;
   localparam int         LCD_VOL_W          = 6;
   localparam int         LCD_FLASH_W        = 2;
   localparam int         LCD_FIELD3_W       = 3;
   // Reset values of the mode settings
   localparam logic [5:0] LCD_VOL_RST        = 6'h20;
   localparam logic [2:0] LCD_PWR_RST        = 3'h0;
   localparam logic [2:0] LCD_RATIO_RST      = 3'h0;
   localparam logic [1:0] LCD_FLASH_RST      = 2'h0;
   // Wishbone register offsets of the host controller
   localparam logic [3:0] LCD_REG_CTRL       = 4'h0; // W: bit8 rs, bits7:0 byte, go
   localparam logic [3:0] LCD_REG_STAT       = 4'h4; // R: bit0 busy
   localparam int         LCD_CTRL_RS_BIT    = 8;
   // Write strobe timing on the link
   localparam int         LCD_CLK_MHZ        = 25;
   localparam int         LCD_STROBE_NS      = 80;
   localparam int         LCD_STROBE_CYC     = (LCD_STROBE_NS * LCD_CLK_MHZ + 999) / 1000;
   localparam logic [3:0] LCD_STROBE_CNT     = 4'(LCD_STROBE_CYC);

   typedef enum logic [1:0] {
      LCD_EXP_CMD    = 2'b00,
      LCD_EXP_VOLUME = 2'b01,
      LCD_EXP_FLASH  = 2'b10
   } lcd_expect_t;

   typedef enum logic [1:0] {
      LCD_PM_NORMAL  = 2'b00,
      LCD_PM_STANDBY = 2'b01,
      LCD_PM_SLEEP   = 2'b10
   } lcd_pmode_t;

   // True when the byte matches code under mask
   function automatic logic lcd_match(input logic [7:0] b, input logic [7:0] code,
                                      input logic [7:0] mask);
      return (b & mask) == code;
   endfunction
endpackage

// ===== verification/lcd_cmd_chk.sv
`timescale 1ns/1ps
// Purpose: Assertions on the link between host end and decoder
// Assumes: One clock, synchronous active-high reset
// Notes:   Helper flops remember the last command and data bytes
module lcd_cmd_chk
   import lcd_cmd_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       register_select,
   input wire logic [7:0] data,
   input wire logic       wr_n,
   input wire logic       display_on_o,
   input wire logic       entire_on_o,
   input wire logic       bias_sel_o,
   input wire logic       com_reverse_o,
   input wire logic [5:0] contrast_volume_o,
   input wire logic       ram_we_o,
   input wire logic [7:0] ram_data_o
);
   logic       wr_prev;
   logic       cap_rs;
   logic [7:0] cap_data;
   logic [7:0] cmd_last;
   logic [7:0] cmd_prev;
   logic [7:0] dat_last;
   logic       done;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Strobe rise ends a transfer
   assign done = wr_n && !wr_prev;
   // Byte captured while strobe is low, so a change at the rise cannot fool us
   always_ff @(posedge clk_i) begin
      wr_prev <= rst_i | wr_n;
      if (!wr_n) begin
         cap_rs   <= register_select;
         cap_data <= data;
      end
      if (rst_i) begin
         cmd_last <= 8'h00;
         cmd_prev <= 8'h00;
         dat_last <= 8'h00;
      end else if (done && !cap_rs) begin
         cmd_prev <= cmd_last;
         cmd_last <= cap_data;
      end else if (done) begin
         dat_last <= cap_data;
      end
   end
   sequence strobe_fell;
      !wr_n && wr_prev;
   endsequence
   sequence show_cmd;
      done && !cap_rs && cap_data == 8'haf;
   endsequence
   strobe_low_a: assert property (strobe_fell |=> !wr_n [*2] ##1 wr_n)
      else $error("Write strobe low time wrong");
   strobe_high_a: assert property (done |-> wr_n [*3])
      else $error("Write strobe high too short");
   link_stable_a: assert property (!wr_n && !wr_prev |-> $stable(data) && $stable(register_select))
      else $error("Link byte moved during strobe");
   disp_latency_a: assert property (show_cmd |-> ##[1:8] display_on_o)
      else $error("Display on came late");
   disp_cmd_a: assert property ($changed(display_on_o) |-> (cmd_last == LCD_CMD_RESET) ?
      !display_on_o : (cmd_last[7:1] == 7'h57 && display_on_o == cmd_last[0]))
      else $error("Display state changed without its command");
   entire_cmd_a: assert property ($changed(entire_on_o) |-> (cmd_last == LCD_CMD_RESET) ?
      !entire_on_o : (cmd_last[7:1] == 7'h52 && entire_on_o == cmd_last[0]))
      else $error("Entire display changed without its command");
   bias_cmd_a: assert property ($changed(bias_sel_o) |-> (cmd_last == LCD_CMD_RESET) ?
      !bias_sel_o : (cmd_last[7:1] == 7'h51 && bias_sel_o == cmd_last[0]))
      else $error("Bias changed without its command");
   com_dir_a: assert property ($changed(com_reverse_o) |-> (cmd_last == LCD_CMD_RESET) ?
      !com_reverse_o : (cmd_last[7:4] == 4'hc && com_reverse_o == cmd_last[3]))
      else $error("Scan direction changed without its command");
   contrast_pair_a: assert property ($changed(contrast_volume_o) |-> (cmd_last == LCD_CMD_RESET) ?
      contrast_volume_o == LCD_VOL_RST :
      (cmd_prev == LCD_CMD_VOLUME && contrast_volume_o == cmd_last[5:0]))
      else $error("Contrast changed outside its pair");
   ram_write_a: assert property (ram_we_o |-> ram_data_o == dat_last ##1 !ram_we_o)
      else $error("RAM write wrong byte or long pulse");
endmodule

// ===== verification/lcd_command_decoder_test.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench, host end driving decoder end over the link
// Assumes: 25 MHz clock, Wishbone classic master tasks
// Notes:   Table rows are rs, code, observed field, expected value
module lcd_command_decoder_test
   import lcd_cmd_pkg::*;
;
   logic        clk_i, rst_i, we_r, cyc, stb, ack, disp, ent, bias, rmw, common_output, ind, tst, osc, gnd, rwe;
   logic [3:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [2:0]  pwr, ratio;
   logic [5:0]  vol;
   logic [1:0]  flash, pst;
   logic [7:0]  rdata;
   int          n_fail, check_count, cycles;
   logic [24:0] tbl [] = '{25'h0_af_00_01, 25'h0_ae_00_00, 25'h0_af_00_01,
      25'h0_a5_01_01, 25'h0_a4_01_00, 25'h0_a3_02_01, 25'h0_a2_02_00,
      25'h0_c8_03_01, 25'h0_c7_03_00, 25'h0_cf_03_01,
      25'h0_2d_04_05, 25'h0_2f_04_07, 25'h0_28_04_00, 25'h0_23_05_03, 25'h0_24_05_04,
      25'h0_81_06_20, 25'h0_ff_06_3f, 25'h0_81_06_3f, 25'h0_c5_06_05,
      25'h1_ae_00_01, 25'h1_77_0e_77,
      25'h0_e0_0b_01, 25'h1_12_0b_01, 25'h0_ee_0b_00,
      25'h0_ad_07_01, 25'h0_fe_08_02, 25'h0_ac_07_00, 25'h0_03_08_03, 25'h0_e3_06_05,
      25'h0_f5_09_01, 25'h0_f0_09_00,
      25'h0_ae_00_00, 25'h0_a5_0a_02, 25'h0_e3_0c_00, 25'h0_e3_0d_01, 25'h1_5a_0e_5a,
      25'h0_af_0a_00, 25'h0_ad_07_01, 25'h0_01_08_01, 25'h0_ae_0a_01,
      25'h0_e2_06_20, 25'h0_e3_01_01, 25'h0_e3_07_00, 25'h0_e3_0a_02,
      25'h0_af_0a_00, 25'h0_e3_0c_01};
   lcd_cmd_if lcd_cmd_if_inst ();
   lcd_cmd_host lcd_cmd_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hf), .wb_we_i(we_r), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
      .wb_ack_o(ack), .link(lcd_cmd_if_inst));
   lcd_cmd_dev lcd_cmd_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(lcd_cmd_if_inst),
      .display_on_o(disp), .entire_on_o(ent), .bias_sel_o(bias), .rmw_mode_o(rmw),
      .com_reverse_o(common_output), .power_mode_o(pwr), .regulator_resistor_ratio_o(ratio),
      .contrast_volume_o(vol), .indicator_on_o(ind), .indicator_flash_mode_o(flash),
      .test_mode_o(tst), .power_state_o(pst), .osc_run_o(osc), .outputs_grounded_o(gnd),
      .ram_we_o(rwe), .ram_data_o(rdata));
   lcd_cmd_chk lcd_cmd_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
      .register_select(lcd_cmd_if_inst.register_select), .data(lcd_cmd_if_inst.data),
      .wr_n(lcd_cmd_if_inst.wr_n), .display_on_o(disp), .entire_on_o(ent), .bias_sel_o(bias),
      .com_reverse_o(common_output), .contrast_volume_o(vol), .ram_we_o(rwe), .ram_data_o(rdata));
   // One field of the decoder picked by index, widened to a byte
   function automatic logic [7:0] obs(input logic [7:0] k);
      logic [119:0] all;
      all = {rdata, 7'h0, gnd, 7'h0, osc, 7'h0, rmw, 6'h0, pst, 7'h0, tst, 6'h0, flash, 7'h0, ind,
             2'h0, vol, 5'h0, ratio, 5'h0, pwr, 7'h0, common_output, 7'h0, bias, 7'h0, ent, 7'h0, disp};
      return all[k*8 +: 8];
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle; request held until ack is sampled high
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      we_r <= w;
      wdat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // Issue one byte, poll busy, then allow the decoder its sync latency
   task automatic send(input logic rs, input logic [7:0] b);
      wb(LCD_REG_CTRL, 1'b1, {23'h0, rs, b});
      q = 32'h1;
      while (q[0] !== 1'b0) wb(LCD_REG_STAT, 1'b0, 32'h0);
      repeat (8) @(posedge clk_i);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // Hang guard, far above the fewer than a thousand cycles the tests need
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      {we_r, cyc, stb, adr, wdat, n_fail, check_count, cycles} = '0;
      rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check({26'h0, vol}, {26'h0, LCD_VOL_RST});
      wb(4'h8, 1'b0, 32'h0);
      check(q, 32'h0);
      $display("register test done");
      foreach (tbl[i]) begin
         send(tbl[i][24], tbl[i][23:16]);
         check({24'h0, obs(tbl[i][15:8])}, {24'h0, tbl[i][7:0]});
      end
      $display("command table test done");
      wrap_up();
   end
endmodule
